/* File: rtl/ppsb_pkg.sv */
package ppsb_pkg;
  // register byte addresses
  localparam logic [7:0] OFF_PIN_ENABLE = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_PAD_CFG = 8'h08;
  localparam logic [7:0] OFF_MODE = 8'h0c;
  localparam logic [7:0] OFF_IN_FIRST = 8'h10;
  localparam logic [7:0] OFF_IN_SECOND = 8'h14;
  localparam logic [7:0] OFF_OUT_FIRST = 8'h18;
  localparam logic [7:0] OFF_OUT_SECOND = 8'h1c;
  localparam logic [7:0] OFF_LOG = 8'h20;
  // pin enable layout
  localparam logic [15:0] PIN_EN_MASK = 16'h47ff;
  localparam logic [15:0] PIN_EN_RESET = 16'h0000;
  localparam int PIN_EN_CS_BIT = 14;
  localparam int PIN_EN_ADDR_LSB = 2;
  localparam int PIN_EN_ADDR_MSB = 10;
  // status layout
  localparam int ST_IN_ALL_FULL = 15;
  localparam int ST_IN_OVF = 14;
  localparam int ST_IN_FULL_LSB = 8;
  localparam int ST_OUT_ALL_EMPTY = 7;
  localparam int ST_OUT_UNF = 6;
  localparam int ST_OUT_EMPTY_LSB = 0;
  localparam logic [3:0] IN_FULL_RESET = 4'h0;
  localparam logic [3:0] OUT_EMPTY_RESET = 4'hf;
  // pad configuration layout
  localparam int PAD_TTL_BIT = 0;
  localparam logic PAD_TTL_RESET = 1'b0;
  // mode register layout
  localparam int MODE_SEL_LSB = 0;
  localparam int MODE_IRQ_LSB = 2;
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_ADDRESSABLE = 2'h1;
  localparam logic [1:0] IRQ_NONE = 2'h0;
  localparam logic [1:0] IRQ_EACH = 2'h1;
  localparam logic [1:0] IRQ_LAST_BYTE = 2'h3;
  localparam logic [1:0] LAST_BYTE_IDX = 2'h3;
  // log fifo shape
  localparam int LOG_DEPTH = 16;
  localparam int LOG_VALID_BIT = 31;

  typedef struct packed {
    logic [1:0] idx;
    logic [7:0] data;
  } ppsb_host_byte_t;

  typedef struct packed {
    logic cs;
    logic rd;
    logic wr;
    logic [1:0] addr;
    logic [7:0] data;
  } ppsb_pins_t;

  localparam ppsb_pins_t PINS_RESET = '{cs: 1'b0, rd: 1'b0, wr: 1'b0, addr: 2'h0, data: 8'h00};
endpackage

/* File: rtl/ppsb_fifo.sv */
`timescale 1ns/1ps
module ppsb_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW-1:0] rd_ptr_d;
  logic [AW:0] count_q;
  logic [WIDTH-1:0] head_q;
  logic push;
  logic pop;

  assign in_ready = (count_q != (AW+1)'(DEPTH));
  assign out_valid = (count_q != '0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  assign rd_ptr_d = pop ? rd_ptr_q + AW'(1) : rd_ptr_q;

  ////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (ce && push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else if (ce) begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + AW'(1);
      end
      rd_ptr_q <= rd_ptr_d;
      count_q <= count_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // registered head, bypassing a write into the slot about to be shown
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      head_q <= '0;
    end else if (ce) begin
      if (push && (wr_ptr_q == rd_ptr_d)) begin
        head_q <= in_data;
      end else begin
        head_q <= mem[rd_ptr_d];
      end
    end
  end

  assign out_data = head_q;
endmodule

/* File: rtl/ppsb_port.sv */
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////
// Contract
// - a set chip-select enable bit routes the chip-select pad to the port, clear leaves port I/O.
// - each set upper address enable bit gives its address pad to the port, clear leaves port I/O.
// - the two lowest enable bits give address pads 1 and 0 to the port as low address or latch.
// - the input-all-full flag is one only while all four input bytes hold data.
// - a host write to a full input byte sets input overflow, cleared only by software writing 0.
// - each input byte full flag is set while unread data waits and cleared by a processor read.
// - the output-all-empty flag is one only while all four output bytes are empty.
// - a host read of an empty output byte sets output underflow, cleared by software writing 0.
// - each output byte empty flag is one while empty and cleared by a processor write of data.
// - in addressable mode host address 00 to 11 pick low/high byte of first then second buffer.
// - the pad configuration bit selects ttl input buffers at one, schmitt buffers at zero.
// - unimplemented bits of pin enable, status and pad configuration read zero, ignore writes.
// - interrupt mode 11 requests an interrupt when buffer byte 3 is read or written.
// - mode 01 is the addressable slave port using strobes, chip select, data and low address.
module ppsb_port (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic host_cs,
  input wire logic host_rd,
  input wire logic host_wr,
  input wire logic [1:0] host_addr,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  output logic pad_cs_port_sel,
  output logic [8:0] pad_addr_port_sel,
  output logic [1:0] pad_low_port_sel,
  output logic pad_ttl_sel,
  output logic interrupt_request,
  output logic log_in_ready
);
  //////////////////////////////////////////////////////////////////
  // declarations
  logic [15:0] pin_en_q;
  logic pad_ttl_q;
  logic [1:0] mode_sel_q;
  logic [1:0] irq_mode_q;
  logic [7:0] in_byte_q [4];
  logic [7:0] out_byte_q [4];
  logic [3:0] in_full_q;
  logic [3:0] out_empty_q;
  logic ovf_q;
  logic unf_q;
  logic [1:0] wr_ptr_q;
  logic [1:0] rd_ptr_q;
  ppsb_pkg::ppsb_pins_t sync1_q;
  ppsb_pkg::ppsb_pins_t sync2_q;
  logic act_wr_q;
  logic act_rd_q;
  logic [7:0] wr_data_q;
  logic [1:0] wr_idx_q;
  logic [1:0] rd_idx_q;
  logic [7:0] data_out_q;
  logic oe_n_q;
  logic irq_q;
  logic cs_eff;
  logic [1:0] addr_eff;
  logic act_wr;
  logic act_rd;
  logic [1:0] cur_idx;
  logic wr_done;
  logic rd_done;
  logic wr_refused;
  logic apb_acc;
  logic apb_wr;
  logic apb_rd;
  logic mapped;
  logic log_valid;
  logic log_pop;
  ppsb_pkg::ppsb_host_byte_t log_in;
  ppsb_pkg::ppsb_host_byte_t log_out;
  logic [15:0] status;

  function automatic logic [3:0] pair_mask(input logic second);
    pair_mask = second ? 4'hc : 4'h3;
  endfunction
  function automatic logic [3:0] byte_mask(input logic [1:0] idx);
    byte_mask = 4'h1 << idx;
  endfunction

  //////////////////////////////////////////////////////////////////
  // pad routing
  assign pad_cs_port_sel = pin_en_q[ppsb_pkg::PIN_EN_CS_BIT];
  assign pad_addr_port_sel = pin_en_q[ppsb_pkg::PIN_EN_ADDR_MSB:ppsb_pkg::PIN_EN_ADDR_LSB];
  assign pad_low_port_sel = pin_en_q[1:0];
  assign pad_ttl_sel = pad_ttl_q;

  //////////////////////////////////////////////////////////////////
  // host pin synchronisers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1_q <= ppsb_pkg::PINS_RESET;
      sync2_q <= ppsb_pkg::PINS_RESET;
    end else if (ce) begin
      sync1_q <= '{cs: host_cs, rd: host_rd, wr: host_wr, addr: host_addr, data: host_data_in};
      sync2_q <= sync1_q;
    end
  end

  // pads left as port I/O do not reach the port
  assign cs_eff = sync2_q.cs & pin_en_q[ppsb_pkg::PIN_EN_CS_BIT];
  assign addr_eff = sync2_q.addr & pin_en_q[1:0];
  assign act_wr = cs_eff & sync2_q.wr;
  assign act_rd = cs_eff & sync2_q.rd;

  // addressable mode uses host address, legacy mode walks the buffers
  always_comb begin
    if (mode_sel_q == ppsb_pkg::MODE_ADDRESSABLE) begin
      cur_idx = addr_eff;
    end else begin
      cur_idx = act_wr ? wr_ptr_q : rd_ptr_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // host strobe tracking, transfer completes as strobe falls
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      act_wr_q <= 1'b0;
      act_rd_q <= 1'b0;
      wr_data_q <= 8'h00;
      wr_idx_q <= 2'h0;
      rd_idx_q <= 2'h0;
    end else if (ce) begin
      act_wr_q <= act_wr;
      act_rd_q <= act_rd;
      if (act_wr) begin
        wr_data_q <= sync2_q.data;
        wr_idx_q <= cur_idx;
      end
      if (act_rd) begin
        rd_idx_q <= cur_idx;
      end
    end
  end
  assign wr_done = act_wr_q & ~act_wr;
  assign rd_done = act_rd_q & ~act_rd;
  assign wr_refused = in_full_q[wr_idx_q] | ~log_in_ready;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      wr_ptr_q <= 2'h0;
      rd_ptr_q <= 2'h0;
    end else if (ce) begin
      if (wr_done && mode_sel_q == ppsb_pkg::MODE_LEGACY) begin
        wr_ptr_q <= wr_ptr_q + 2'h1;
      end
      if (rd_done && mode_sel_q == ppsb_pkg::MODE_LEGACY) begin
        rd_ptr_q <= rd_ptr_q + 2'h1;
      end
    end
  end

  // host read data
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      data_out_q <= 8'h00;
      oe_n_q <= 1'b1;
    end else if (ce) begin
      data_out_q <= out_byte_q[cur_idx];
      oe_n_q <= ~act_rd;
    end
  end
  assign host_data_out = data_out_q;
  assign host_data_oe_n = oe_n_q;

  //////////////////////////////////////////////////////////////////
  // apb slave
  assign apb_acc = psel & penable;
  assign apb_wr = apb_acc & pwrite;
  assign apb_rd = apb_acc & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = apb_acc & ~mapped;

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_en_q <= ppsb_pkg::PIN_EN_RESET;
      pad_ttl_q <= ppsb_pkg::PAD_TTL_RESET;
      mode_sel_q <= ppsb_pkg::MODE_LEGACY;
      irq_mode_q <= ppsb_pkg::IRQ_NONE;
    end else if (ce && apb_wr) begin
      if (paddr == ppsb_pkg::OFF_PIN_ENABLE) begin
        pin_en_q <= pwdata[15:0] & ppsb_pkg::PIN_EN_MASK;
      end else if (paddr == ppsb_pkg::OFF_PAD_CFG) begin
        pad_ttl_q <= pwdata[ppsb_pkg::PAD_TTL_BIT];
      end else if (paddr == ppsb_pkg::OFF_MODE) begin
        mode_sel_q <= pwdata[ppsb_pkg::MODE_SEL_LSB +: 2];
        irq_mode_q <= pwdata[ppsb_pkg::MODE_IRQ_LSB +: 2];
      end
    end
  end

  // output buffers written by software
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        out_byte_q[i] <= 8'h00;
      end
    end else if (ce && apb_wr) begin
      if (paddr == ppsb_pkg::OFF_OUT_FIRST) begin
        out_byte_q[0] <= pwdata[7:0];
        out_byte_q[1] <= pwdata[15:8];
      end else if (paddr == ppsb_pkg::OFF_OUT_SECOND) begin
        out_byte_q[2] <= pwdata[7:0];
        out_byte_q[3] <= pwdata[15:8];
      end
    end
  end

  // input buffers written by the host
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < 4; i++) begin
        in_byte_q[i] <= 8'h00;
      end
    end else if (ce && wr_done && !wr_refused) begin
      in_byte_q[wr_idx_q] <= wr_data_q;
    end
  end

  //////////////////////////////////////////////////////////////////
  // buffer flags, hardware set wins over software clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      in_full_q <= ppsb_pkg::IN_FULL_RESET;
      out_empty_q <= ppsb_pkg::OUT_EMPTY_RESET;
    end else if (ce) begin
      in_full_q <= (in_full_q
        & ~((apb_rd && paddr == ppsb_pkg::OFF_IN_FIRST) ? pair_mask(1'b0) : 4'h0)
        & ~((apb_rd && paddr == ppsb_pkg::OFF_IN_SECOND) ? pair_mask(1'b1) : 4'h0))
        | ((wr_done && !wr_refused) ? byte_mask(wr_idx_q) : 4'h0);
      out_empty_q <= (out_empty_q
        & ~((apb_wr && paddr == ppsb_pkg::OFF_OUT_FIRST) ? pair_mask(1'b0) : 4'h0)
        & ~((apb_wr && paddr == ppsb_pkg::OFF_OUT_SECOND) ? pair_mask(1'b1) : 4'h0))
        | (rd_done ? byte_mask(rd_idx_q) : 4'h0);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
    end else if (ce) begin
      if (wr_done && wr_refused) begin
        ovf_q <= 1'b1;
      end else if (apb_wr && paddr == ppsb_pkg::OFF_STATUS && !pwdata[ppsb_pkg::ST_IN_OVF]) begin
        ovf_q <= 1'b0;
      end
      if (rd_done && out_empty_q[rd_idx_q]) begin
        unf_q <= 1'b1;
      end else if (apb_wr && paddr == ppsb_pkg::OFF_STATUS && !pwdata[ppsb_pkg::ST_OUT_UNF]) begin
        unf_q <= 1'b0;
      end
    end
  end

  always_comb begin
    status = 16'h0000;
    status[ppsb_pkg::ST_IN_ALL_FULL] = &in_full_q;
    status[ppsb_pkg::ST_IN_OVF] = ovf_q;
    status[ppsb_pkg::ST_IN_FULL_LSB +: 4] = in_full_q;
    status[ppsb_pkg::ST_OUT_ALL_EMPTY] = &out_empty_q;
    status[ppsb_pkg::ST_OUT_UNF] = unf_q;
    status[ppsb_pkg::ST_OUT_EMPTY_LSB +: 4] = out_empty_q;
  end

  //////////////////////////////////////////////////////////////////
  // interrupt request pulse
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else if (ce) begin
      if (irq_mode_q == ppsb_pkg::IRQ_LAST_BYTE) begin
        irq_q <= (wr_done && wr_idx_q == ppsb_pkg::LAST_BYTE_IDX)
          || (rd_done && rd_idx_q == ppsb_pkg::LAST_BYTE_IDX);
      end else begin
        irq_q <= (irq_mode_q == ppsb_pkg::IRQ_EACH) && (wr_done || rd_done);
      end
    end
  end
  assign interrupt_request = irq_q;

  //////////////////////////////////////////////////////////////////
  // log of accepted host bytes, drained by software
  assign log_in = '{idx: wr_idx_q, data: wr_data_q};
  assign log_pop = ce & apb_rd & (paddr == ppsb_pkg::OFF_LOG);

  ppsb_fifo #(.WIDTH($bits(ppsb_pkg::ppsb_host_byte_t)), .DEPTH(ppsb_pkg::LOG_DEPTH)) u_log (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .in_valid(wr_done & ~in_full_q[wr_idx_q]),
    .in_ready(log_in_ready),
    .in_data(log_in),
    .out_valid(log_valid),
    .out_ready(log_pop),
    .out_data(log_out)
  );

  //////////////////////////////////////////////////////////////////
  // read mux
  always_comb begin
    mapped = 1'b1;
    if (paddr == ppsb_pkg::OFF_PIN_ENABLE) begin
      prdata = {16'h0000, pin_en_q};
    end else if (paddr == ppsb_pkg::OFF_STATUS) begin
      prdata = {16'h0000, status};
    end else if (paddr == ppsb_pkg::OFF_PAD_CFG) begin
      prdata = {31'h00000000, pad_ttl_q};
    end else if (paddr == ppsb_pkg::OFF_MODE) begin
      prdata = {28'h0000000, irq_mode_q, mode_sel_q};
    end else if (paddr == ppsb_pkg::OFF_IN_FIRST) begin
      prdata = {16'h0000, in_byte_q[1], in_byte_q[0]};
    end else if (paddr == ppsb_pkg::OFF_IN_SECOND) begin
      prdata = {16'h0000, in_byte_q[3], in_byte_q[2]};
    end else if (paddr == ppsb_pkg::OFF_OUT_FIRST) begin
      prdata = {16'h0000, out_byte_q[1], out_byte_q[0]};
    end else if (paddr == ppsb_pkg::OFF_OUT_SECOND) begin
      prdata = {16'h0000, out_byte_q[3], out_byte_q[2]};
    end else if (paddr == ppsb_pkg::OFF_LOG) begin
      prdata = {log_valid, 21'h000000, log_out};
    end else begin
      mapped = 1'b0;
      prdata = 32'h00000000;
    end
  end
endmodule

/* File: tb/ppsb_port_checker.sv */
`timescale 1ns/1ps
module ppsb_port_checker (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic pad_cs_port_sel,
  input wire logic [8:0] pad_addr_port_sel,
  input wire logic [1:0] pad_low_port_sel,
  input wire logic pad_ttl_sel,
  input wire logic interrupt_request,
  input wire logic log_in_ready
);
  logic wr_pin;
  logic wr_pad;
  logic rd_st;
  assign wr_pin = psel && penable && pwrite && ce && paddr == ppsb_pkg::OFF_PIN_ENABLE;
  assign wr_pad = psel && penable && pwrite && ce && paddr == ppsb_pkg::OFF_PAD_CFG;
  assign rd_st = psel && paddr == ppsb_pkg::OFF_STATUS;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  //////////////////////////////////////////////////////////////////
  chk_cs_route: assert property (wr_pin |=> pad_cs_port_sel == $past(pwdata[14]))
    else $error("chip select routing wrong");
  chk_addr_route: assert property (wr_pin |=> pad_addr_port_sel == $past(pwdata[10:2]))
    else $error("address pad routing wrong");
  chk_low_route: assert property (wr_pin ##1 1'b1 |-> pad_low_port_sel == $past(pwdata[1:0]))
    else $error("low address pad routing wrong");
  chk_ttl_select: assert property (wr_pad |=> pad_ttl_sel == $past(pwdata[0]))
    else $error("input buffer type wrong");
  chk_pin_readback: assert property (psel && paddr == ppsb_pkg::OFF_PIN_ENABLE |->
    prdata == {17'h0, pad_cs_port_sel, 3'h0, pad_addr_port_sel, pad_low_port_sel})
    else $error("pin enable readback wrong");
  chk_status_rsv: assert property (rd_st |-> prdata[31:16] == 16'h0 && prdata[13:12] == 2'h0
    && prdata[5:4] == 2'h0)
    else $error("status reserved bits set");
  chk_in_all_full: assert property (rd_st |-> prdata[15] == &prdata[11:8])
    else $error("input all full flag wrong");
  chk_out_all_empty: assert property (rd_st |-> prdata[7] == &prdata[3:0])
    else $error("output all empty flag wrong");
  chk_bad_addr: assert property (psel && penable && paddr > 8'h23 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_irq_pulse: assert property (interrupt_request |=> !interrupt_request)
    else $error("interrupt longer than one cycle");
  cover property (pslverr);
  cover property (interrupt_request);
  cover property (!log_in_ready);
endmodule
bind ppsb_port ppsb_port_checker i_ppsb_port_checker (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .pad_cs_port_sel(pad_cs_port_sel),
  .pad_addr_port_sel(pad_addr_port_sel), .pad_low_port_sel(pad_low_port_sel),
  .pad_ttl_sel(pad_ttl_sel), .interrupt_request(interrupt_request),
  .log_in_ready(log_in_ready));

/* File: tb/ppsb_host_model.sv */
`timescale 1ns/1ps
module ppsb_host_model (
  input wire logic clk_sys,
  output logic host_cs,
  output logic host_rd,
  output logic host_wr,
  output logic [1:0] host_addr,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out
);
  initial begin
    host_cs = 1'b0;
    host_rd = 1'b0;
    host_wr = 1'b0;
    host_addr = 2'h0;
    host_data_in = 8'h5a;
  end
  // one strobe: held 5 cycles, then 4 low before the lines are let go
  task automatic xfer(input logic w, input logic [1:0] i, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clk_sys);
    host_cs <= 1'b1;
    host_addr <= i;
    host_data_in <= d;
    host_wr <= w;
    host_rd <= !w;
    repeat (5) @(posedge clk_sys);
    q = host_data_out;
    host_wr <= 1'b0;
    host_rd <= 1'b0;
    host_cs <= 1'b0;
    repeat (4) @(posedge clk_sys);
    host_addr <= ~i;
    host_data_in <= ~d;
    repeat (2) @(posedge clk_sys);
  endtask
endmodule

/* File: tb/ppsb_port_test.sv */
`timescale 1ns/1ps
module ppsb_port_test;
  logic clk_sys, rst, ce, psel, penable, pwrite, pready, pslverr, err;
  logic host_cs, host_rd, host_wr, oe_n, pcs, ttl, irq, lrdy;
  logic [7:0] paddr, hdi, hdo, hb, e;
  logic [31:0] pwdata, prdata, rv;
  logic [1:0] host_addr, plow;
  logic [8:0] asel;
  logic [15:0] pv [4] = '{16'hffff, 16'h4000, 16'h07fc, 16'h0003};
  int n_fail, compares, n_irq, i;
  ppsb_port i_ppsb_port (.clk_sys(clk_sys), .rst(rst), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .host_cs(host_cs), .host_rd(host_rd), .host_wr(host_wr),
    .host_addr(host_addr), .host_data_in(hdi), .host_data_out(hdo), .host_data_oe_n(oe_n),
    .pad_cs_port_sel(pcs), .pad_addr_port_sel(asel), .pad_low_port_sel(plow),
    .pad_ttl_sel(ttl), .interrupt_request(irq), .log_in_ready(lrdy));
  ppsb_host_model i_ppsb_host_model (.clk_sys(clk_sys), .host_cs(host_cs), .host_rd(host_rd),
    .host_wr(host_wr), .host_addr(host_addr), .host_data_in(hdi), .host_data_out(hdo));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (irq === 1'b1) n_irq <= n_irq + 1;
  //////////////////////////////////////////////////////////////////
  task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task tally_and_finish;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rv = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task hw(input logic [1:0] k, input logic [7:0] d);
    i_ppsb_host_model.xfer(1'b1, k, d, hb);
  endtask
  task hr(input logic [1:0] k);
    i_ppsb_host_model.xfer(1'b0, k, 8'h00, hb);
  endtask
  //////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_fail++;
    $display("watchdog expired");
    tally_and_finish;
  end
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("status reset", rv, 32'h0000008f);
    apb(1'b0, ppsb_pkg::OFF_PAD_CFG, 32'h0);
    check("pad reset", rv, 32'h0);
    $display("test reset done");
    foreach (pv[k]) begin
      apb(1'b1, ppsb_pkg::OFF_PIN_ENABLE, {16'hffff, pv[k]});
      apb(1'b0, ppsb_pkg::OFF_PIN_ENABLE, 32'h0);
      check("pin enable", rv, {16'h0, pv[k] & 16'h47ff});
      check("cs sel", {31'h0, pcs}, {31'h0, pv[k][14]});
      check("addr sel", {23'h0, asel}, {23'h0, pv[k][10:2]});
      check("low sel", {30'h0, plow}, {30'h0, pv[k][1:0]});
    end
    for (i = 1; i >= 0; i--) begin
      apb(1'b1, ppsb_pkg::OFF_PAD_CFG, i[0] ? 32'hffffffff : 32'h0);
      apb(1'b0, ppsb_pkg::OFF_PAD_CFG, 32'h0);
      check("pad cfg", rv, {31'h0, i[0]});
      check("ttl sel", {31'h0, ttl}, {31'h0, i[0]});
    end
    apb(1'b0, 8'h24, 32'h0);
    check("unmapped", {err, rv[30:0]}, 32'h80000000);
    $display("test registers done");
    apb(1'b1, ppsb_pkg::OFF_PIN_ENABLE, 32'h4003);
    apb(1'b1, ppsb_pkg::OFF_MODE, 32'hd);
    for (i = 0; i < 4; i++) begin
      hw(i[1:0], 8'ha0 + i[7:0]);
      apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
      e = (i == 3) ? 8'h8f : (8'h02 << i) - 8'h01;
      check("in full", {24'h0, rv[15:8]}, {24'h0, e});
    end
    check("irq count", n_irq, 1);
    hw(2'h2, 8'h55);
    apb(1'b0, ppsb_pkg::OFF_IN_FIRST, 32'h0);
    check("in first", rv, 32'h0000a1a0);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("overflow", {24'h0, rv[15:8]}, 32'h4c);
    apb(1'b0, ppsb_pkg::OFF_IN_SECOND, 32'h0);
    check("in second", rv, 32'h0000a3a2);
    apb(1'b1, ppsb_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("ovf clear", {24'h0, rv[15:8]}, 32'h0);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, ppsb_pkg::OFF_LOG, 32'h0);
      check("log", rv, {22'h200000, i[1:0], 8'ha0 + i[7:0]});
    end
    for (i = 0; i < 20 && rv[31] === 1'b1; i++) apb(1'b0, ppsb_pkg::OFF_LOG, 32'h0);
    $display("test input side done");
    for (i = 0; i < 16; i++) begin
      hw(i[1:0], i[7:0]);
      if (i % 4 == 3) begin
        apb(1'b0, ppsb_pkg::OFF_IN_FIRST, 32'h0);
        apb(1'b0, ppsb_pkg::OFF_IN_SECOND, 32'h0);
      end
    end
    check("log full", {31'h0, lrdy}, 32'h0);
    hw(2'h0, 8'hee);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("refused", {24'h0, rv[15:8]}, 32'h40);
    for (i = 0; i < 17; i++) begin
      apb(1'b0, ppsb_pkg::OFF_LOG, 32'h0);
      check("drain", rv, (i == 16) ? 32'h0 : {22'h200000, i[1:0], i[7:0]});
    end
    check("log free", {31'h0, lrdy}, 32'h1);
    $display("test buffering done");
    apb(1'b1, ppsb_pkg::OFF_OUT_FIRST, 32'h2211);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("out empty", {24'h0, rv[7:0]}, 32'h0c);
    hr(2'h1);
    check("host rd 1", {24'h0, hb}, 32'h22);
    hr(2'h0);
    check("host rd 0", {24'h0, hb}, 32'h11);
    hr(2'h2);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("underflow", {31'h0, rv[6]}, 32'h1);
    apb(1'b1, ppsb_pkg::OFF_STATUS, 32'h0);
    apb(1'b0, ppsb_pkg::OFF_STATUS, 32'h0);
    check("unf clear", {31'h0, rv[6]}, 32'h0);
    check("oe idle", {31'h0, oe_n}, 32'h1);
    $display("test output side done");
    apb(1'b1, ppsb_pkg::OFF_MODE, 32'h4);
    i = n_irq;
    hw(2'h3, 8'h31);
    hw(2'h3, 8'h32);
    apb(1'b0, ppsb_pkg::OFF_IN_FIRST, 32'h0);
    check("legacy order", rv, 32'h00003231);
    check("irq each", n_irq - i, 2);
    $display("test legacy done");
    tally_and_finish;
  end
endmodule
